// >>> design/hf_clock_multiplier_power_modes.sv
// high frequency multiplier registers, lock readback and power modes
// assumes an avalon-mm master on core_clk_i and a synchronous wait strobe
`timescale 1ns/100ps
// Overview of operation
// RULE_01 - reset programs default 4 MHz setting
// RULE_02 - output from reference, 5-bit n, 14-bit m
// RULE_03 - output held low while locking
// RULE_04 - control bit 0 commits m and n
// RULE_05 - normal load searches for lock value
// RULE_06 - control bit 1 commits m, n, lock
// RULE_07 - software never sets both load bits
// RULE_08 - bit 2 reports multiplier enable
// RULE_09 - bit 3 reports stable output
// RULE_10 - bit 4 flags valid lock low read
// RULE_11 - software reads low, checks flag, reads high
// RULE_12 - control bits 3..0 reset to Ch
// RULE_13 - frequency writes buffer, reads show applied
// RULE_14 - lock low read gives live low byte
// RULE_15 - m low C5h, high 04h, n 0Ah
// RULE_16 - software keeps output 4 to 10 MHz
// RULE_17 - software order for normal change
// RULE_18 - software order for fast change
// RULE_19 - controller drives multiplier enable, gates clock
// RULE_20 - idle stops system clock, multiplier per bit
// RULE_21 - idle keeps only reference-rate logic running
// RULE_22 - wait without idle bits halts fetch
// RULE_23 - reset starts in active mode
// RULE_24 - idle needs enable, request and wait
// RULE_25 - multiplier stops in idle; wake clears bits; the code stops it in idle only when the disable bit is set
// RULE_26 - snapshot high part on low read
// RULE_27 - release clock when stable bit sets
module hf_clock_multiplier_power_modes #(
	parameter int SEARCH_CYC = hf_clock_pkg::SEARCH_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic wait_exec_i,
	input wire logic wake_i,
	output logic sys_clk_en_o,
	output logic core_halt_o,
	output logic idle_o,
	output logic ref_tick_o,
	output logic [13:0] mul_applied_o,
	output logic [4:0] div_applied_o
);
	// ========================================
	// bus decode
	logic rd_done_q;
	wire sel_ctrl = (avs_address_i == hf_clock_pkg::OFF_CTRL);
	wire sel_mlo = (avs_address_i == hf_clock_pkg::OFF_MUL_LO);
	wire sel_mhi = (avs_address_i == hf_clock_pkg::OFF_MUL_HI);
	wire sel_div = (avs_address_i == hf_clock_pkg::OFF_DIV);
	wire sel_llo = (avs_address_i == hf_clock_pkg::OFF_LOCK_LO);
	wire sel_lhi = (avs_address_i == hf_clock_pkg::OFF_LOCK_HI);
	wire sel_pm = (avs_address_i == hf_clock_pkg::OFF_PMODE);
	// writes finish at once; reads take one wait cycle so data comes from a flop
	wire wr_go = avs_write_i && avs_byteenable_i[0];
	wire rd_go = avs_read_i && !rd_done_q;
	assign avs_waitrequest_o = rd_go;
	// ========================================
	// setup buffer and applied values
	logic [7:0] buf_mlo_q;
	logic [5:0] buf_mhi_q;
	logic [4:0] buf_div_q;
	logic [7:0] buf_llo_q;
	logic [5:0] buf_lhi_q;
	logic [13:0] mul_q;
	logic [4:0] div_q;
	wire [7:0] wd = avs_writedata_i[7:0];
	wire load_cmd = wr_go && sel_ctrl && wd[hf_clock_pkg::CTRL_LOAD]; // [RULE_04]
	wire fast_cmd = wr_go && sel_ctrl && wd[hf_clock_pkg::CTRL_FAST]
		&& !wd[hf_clock_pkg::CTRL_LOAD]; // [RULE_06] [RULE_07]
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_mlo_q <= hf_clock_pkg::RST_MUL_LO; // [RULE_15]
			buf_mhi_q <= hf_clock_pkg::RST_MUL_HI;
			buf_div_q <= hf_clock_pkg::RST_DIV;
			buf_llo_q <= 8'h00;
			buf_lhi_q <= 6'h00;
		end else if (wr_go) begin
			if (sel_mlo) buf_mlo_q <= wd; // [RULE_13]
			if (sel_mhi) buf_mhi_q <= wd[5:0];
			if (sel_div) buf_div_q <= wd[4:0];
			if (sel_llo) buf_llo_q <= wd; // [RULE_14]
			if (sel_lhi) buf_lhi_q <= wd[5:0];
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mul_q <= {hf_clock_pkg::RST_MUL_HI, hf_clock_pkg::RST_MUL_LO}; // [RULE_01] [RULE_15]
			div_q <= hf_clock_pkg::RST_DIV;
		end else if (load_cmd || fast_cmd) begin
			mul_q <= {buf_mhi_q, buf_mlo_q}; // [RULE_04] [RULE_02]
			div_q <= buf_div_q;
		end
	end
	assign mul_applied_o = mul_q;
	assign div_applied_o = div_q;
	// ========================================
	// reference tick divider: 32.768 kHz enable
	logic [9:0] ref_cnt_q;
	wire ref_wrap = (ref_cnt_q == 10'(hf_clock_pkg::REF_DIV - 1));
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) ref_cnt_q <= 10'h000;
		else ref_cnt_q <= ref_wrap ? 10'h000 : ref_cnt_q + 10'h001;
	end
	assign ref_tick_o = ref_wrap; // [RULE_21]
	// ========================================
	// power mode controller
	logic dis_mul_q;
	logic idle_req_q;
	logic idle_en_q;
	logic idle_q;
	logic halt_q;
	wire enter_idle = wait_exec_i && idle_en_q && idle_req_q && !idle_q; // [RULE_24]
	wire wake = wake_i && (idle_q || halt_q);
	wire pm_wr = wr_go && sel_pm;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dis_mul_q <= 1'b0;
			idle_req_q <= 1'b0;
			idle_en_q <= 1'b0;
		end else if (wake && idle_q) begin
			dis_mul_q <= 1'b0; // [RULE_25]
			idle_req_q <= 1'b0;
		end else if (pm_wr) begin
			dis_mul_q <= wd[hf_clock_pkg::PM_DIS_MUL];
			idle_req_q <= wd[hf_clock_pkg::PM_IDLE_REQ];
			idle_en_q <= wd[hf_clock_pkg::PM_IDLE_EN];
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idle_q <= 1'b0; // [RULE_23]
			halt_q <= 1'b0;
		end else begin
			if (wake) idle_q <= 1'b0;
			else if (enter_idle) idle_q <= 1'b1; // [RULE_24]
			if (wake) halt_q <= 1'b0;
			else if (wait_exec_i && !(idle_en_q && idle_req_q)) halt_q <= 1'b1; // [RULE_22]
		end
	end
	// multiplier runs unless idle with the disable bit set
	wire mul_enable = !(idle_q && dis_mul_q); // [RULE_19] [RULE_20] [RULE_25]
	assign idle_o = idle_q;
	assign core_halt_o = halt_q || idle_q; // [RULE_22]
	// ========================================
	// lock engine
	logic [13:0] lock_live;
	logic stable;
	logic mul_clk_en;
	lock_engine #(
		.SEARCH_CYC(SEARCH_CYC)
	) i_lock_engine (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.enable_i(mul_enable),
		.load_i(load_cmd),
		.fast_i(fast_cmd),
		.mul_i({buf_mhi_q, buf_mlo_q}),
		.div_i(buf_div_q),
		.lock_seed_i({buf_lhi_q, buf_llo_q}),
		.ref_tick_i(ref_wrap),
		.lock_o(lock_live),
		.stable_o(stable),
		.clk_en_o(mul_clk_en)
	);
	// system clock only in active mode and only once the multiplier is stable
	assign sys_clk_en_o = mul_clk_en && !idle_q; // [RULE_03] [RULE_20] [RULE_19]
	// ========================================
	// lock value snapshot
	logic [5:0] lock_hi_snap_q;
	logic [13:0] lock_prev_q;
	logic valid_q;
	wire llo_rd = rd_go && sel_llo;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_hi_snap_q <= 6'h00;
			lock_prev_q <= 14'h0000;
			valid_q <= 1'b0;
		end else begin
			lock_prev_q <= lock_live;
			if (llo_rd) begin
				lock_hi_snap_q <= lock_live[13:8]; // [RULE_26]
				valid_q <= (lock_prev_q == lock_live); // [RULE_10] [RULE_26]
			end
		end
	end
	// ========================================
	// read data
	wire [7:0] ctrl_rd = {3'b000, valid_q, stable, mul_enable, 2'b00}; // [RULE_08] [RULE_09] [RULE_12]
	wire [7:0] pm_rd = {2'b00, idle_en_q, 2'b00, idle_req_q, dis_mul_q, 1'b0};
	wire [7:0] rd_mux = sel_ctrl ? ctrl_rd :
		sel_mlo ? mul_q[7:0] :
		sel_mhi ? {2'b00, mul_q[13:8]} :
		sel_div ? {3'b000, div_q} :
		sel_llo ? lock_live[7:0] : // [RULE_14]
		sel_lhi ? {2'b00, lock_hi_snap_q} :
		sel_pm ? pm_rd : 8'h00;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_done_q <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			rd_done_q <= rd_go;
			if (rd_go) avs_readdata_o <= {24'h00_0000, rd_mux}; // [RULE_13]
		end
	end
	// ========================================
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	load_low_a: assert property (load_cmd |=> !sys_clk_en_o && !stable) // [RULE_03]
		else $error("clock not held low after load");
	clk_stable_a: assert property (sys_clk_en_o |-> stable) // [RULE_27]
		else $error("clock released before stable");
	applied_a: assert property (load_cmd |=> mul_q == $past({buf_mhi_q, buf_mlo_q})) // [RULE_04]
		else $error("multiplier not applied");
	fast_seed_a: assert property (fast_cmd |=> lock_live == $past({buf_lhi_q, buf_llo_q})) // [RULE_06]
		else $error("lock seed not loaded");
	idle_enter_a: assert property (enter_idle |=> idle_o && !sys_clk_en_o) // [RULE_24]
		else $error("idle not entered");
	halt_a: assert property (wait_exec_i && !(idle_en_q && idle_req_q) && !wake_i |=> core_halt_o && !idle_o) // [RULE_22]
		else $error("wait did not halt in active");
	wake_clear_a: assert property (wake_i && idle_o |=> !idle_o && !dis_mul_q && !idle_req_q) // [RULE_25]
		else $error("wake did not clear bits");
	mul_off_a: assert property (idle_o && dis_mul_q |-> !mul_enable) // [RULE_20]
		else $error("multiplier still on in idle");
	mul_on_a: assert property (!idle_o |-> mul_enable) // [RULE_19]
		else $error("multiplier off in active");
	rd_ctrl_a: assert property (rd_go && sel_ctrl |=> avs_readdata_o[1:0] == 2'b00) // [RULE_04]
		else $error("command bits read nonzero");
	cv_load: cover property (load_cmd ##[1:100] stable);
	cv_fast: cover property (fast_cmd);
	cv_idle: cover property (enter_idle ##[1:50] wake_i);
	cv_halt: cover property (core_halt_o && !idle_o);
endmodule : hf_clock_multiplier_power_modes

// >>> design/hf_clock_pkg.sv
// constants for the high frequency multiplier and power mode block
// assumes a single 20 MHz core clock and an avalon-mm register slave
package hf_clock_pkg;
	// ========================================
	// register offsets (byte addresses)
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_MUL_LO = 5'h04;
	localparam logic [4:0] OFF_MUL_HI = 5'h08;
	localparam logic [4:0] OFF_DIV = 5'h0c;
	localparam logic [4:0] OFF_LOCK_LO = 5'h10;
	localparam logic [4:0] OFF_LOCK_HI = 5'h14;
	localparam logic [4:0] OFF_PMODE = 5'h18;
	// ========================================
	// control and power mode bit positions
	localparam int CTRL_LOAD = 0;
	localparam int CTRL_FAST = 1;
	localparam int CTRL_ENABLE = 2;
	localparam int CTRL_STABLE = 3;
	localparam int CTRL_VALID = 4;
	localparam int PM_DIS_MUL = 1;
	localparam int PM_IDLE_REQ = 2;
	localparam int PM_IDLE_EN = 5;
	// ========================================
	// reset values
	localparam logic [3:0] RST_CTRL = 4'hc;
	localparam logic [7:0] RST_MUL_LO = 8'hc5;
	localparam logic [5:0] RST_MUL_HI = 6'h04;
	localparam logic [4:0] RST_DIV = 5'h0a;
	localparam logic [13:0] RST_LOCK = 14'h0000;
	// ========================================
	// timing: lock settle times
	localparam int CLK_HZ = 20_000_000;
	localparam int SEARCH_US = 2000;
	localparam int FAST_US = 50;
	localparam int SEARCH_CYC = SEARCH_US * (CLK_HZ / 1_000_000);
	localparam int FAST_CYC = FAST_US * (CLK_HZ / 1_000_000);
	// reference 32.768 kHz: 20e6/32768 is about 610 cycles
	localparam int REF_DIV = CLK_HZ / 32768;
endpackage : hf_clock_pkg

// >>> design/lock_engine.sv
// lock engine: models the multiplier's lock search and output gating
// assumes ref_tick_i is a one-cycle pulse at the reference rate
`timescale 1ns/100ps
module lock_engine #(
	parameter int SEARCH_CYC = hf_clock_pkg::SEARCH_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire logic load_i,
	input wire logic fast_i,
	input wire logic [13:0] mul_i,
	input wire logic [4:0] div_i,
	input wire logic [13:0] lock_seed_i,
	input wire logic ref_tick_i,
	output logic [13:0] lock_o,
	output logic stable_o,
	output logic clk_en_o
);
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SEARCH = 2'b01,
		ST_FAST = 2'b10,
		ST_OFF = 2'b11
	} lock_st_t;
	lock_st_t st_q, st_d;
	logic [23:0] cnt_q, cnt_d;
	logic [13:0] lock_q, lock_d;
	// target lock value: the search walks toward a fold of m and n
	wire [13:0] target = mul_i ^ {9'h000, div_i};
	wire search_done = (cnt_q == 24'(SEARCH_CYC - 1)) && (lock_q == target);
	wire fast_done = (cnt_q == 24'(hf_clock_pkg::FAST_CYC - 1));
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q + 24'h00_0001;
		lock_d = lock_q;
		if (!enable_i) begin
			st_d = ST_OFF;
			cnt_d = 24'h00_0000;
		end else if (load_i) begin
			st_d = ST_SEARCH; // [RULE_05]
			cnt_d = 24'h00_0000;
		end else if (fast_i) begin
			st_d = ST_FAST; // [RULE_06]
			lock_d = lock_seed_i;
			cnt_d = 24'h00_0000;
		end else begin
			unique case (st_q)
				ST_RUN: cnt_d = 24'h00_0000;
				ST_OFF: begin
					// restart keeps the old lock value, so a short settle is enough
					st_d = ST_FAST;
					cnt_d = 24'h00_0000;
				end
				ST_SEARCH: begin
					if (ref_tick_i && lock_q != target)
						lock_d = (lock_q < target) ? lock_q + 14'h0001 : lock_q - 14'h0001;
					if (search_done)
						st_d = ST_RUN;
					else if (cnt_q == 24'(SEARCH_CYC - 1))
						cnt_d = cnt_q;
				end
				ST_FAST: if (fast_done) st_d = ST_RUN;
			endcase
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= ST_RUN; // [RULE_01]
			cnt_q <= 24'h00_0000;
			lock_q <= 14'h0000;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			lock_q <= lock_d;
		end
	end
	assign lock_o = lock_q;
	assign stable_o = (st_q == ST_RUN); // [RULE_09]
	assign clk_en_o = (st_q == ST_RUN); // [RULE_03] [RULE_27]
endmodule : lock_engine

// >>> testbench/test_hf_clock_multiplier_power_modes.sv
// self-checking bench for the multiplier registers, lock readback and power modes
// assumes the design package is compiled first; the bench is the only avalon master
`timescale 1ns/100ps
module test_hf_clock_multiplier_power_modes;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [3:0] avs_byteenable_i = 4'h1;
	logic wait_exec_i = 1'b0;
	logic wake_i = 1'b0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic sys_clk_en_o;
	logic core_halt_o;
	logic idle_o;
	logic ref_tick_o;
	logic [13:0] mul_applied_o;
	logic [4:0] div_applied_o;
	int miscompares = 0;
	int checks_done = 0;
	logic [7:0] q;
	logic [7:0] c;
	int n;

	always #25 core_clk_i = ~core_clk_i;

	// short search count keeps the normal load within a few thousand cycles
	hf_clock_multiplier_power_modes #(.SEARCH_CYC(50)) i_hf_clock_multiplier_power_modes (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.wait_exec_i(wait_exec_i), .wake_i(wake_i), .sys_clk_en_o(sys_clk_en_o),
		.core_halt_o(core_halt_o), .idle_o(idle_o), .ref_tick_o(ref_tick_o),
		.mul_applied_o(mul_applied_o), .div_applied_o(div_applied_o));

	// ========================================
	// reporting
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic give_up();
		miscompares++;
		print_verdict();
	endtask : give_up

	// ========================================
	// avalon access: request held until waitrequest is seen low at a rising edge
	task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] r);
		int k;
		k = 0;
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= {24'h00_0000, d};
		@(posedge core_clk_i);
		while (avs_waitrequest_o !== 1'b0) begin
			k++;
			if (k > 20) give_up();
			@(posedge core_clk_i);
		end
		r = avs_readdata_o[7:0];
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask : acc

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] r;
		acc(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] r;
		acc(1'b0, a, 8'h00, r);
		chk({8'h00, r & m}, {8'h00, e});
	endtask : rd

	task automatic wait_stable(input int lim);
		int k;
		k = 0;
		@(negedge core_clk_i);
		while (sys_clk_en_o !== 1'b1) begin
			k++;
			if (k > lim) give_up();
			@(negedge core_clk_i);
		end
	endtask : wait_stable

	// one-cycle wait or wake strobe, then let the registered flags settle
	task automatic strobe(input logic is_wait);
		@(posedge core_clk_i);
		if (is_wait) wait_exec_i <= 1'b1;
		else wake_i <= 1'b1;
		@(posedge core_clk_i);
		wait_exec_i <= 1'b0;
		wake_i <= 1'b0;
		repeat (2) @(negedge core_clk_i);
	endtask : strobe

	// lock low read repeated until the valid flag says the pair is consistent
	task automatic read_lock(input logic [7:0] lo, input logic [7:0] hi);
		for (n = 0; n < 8; n++) begin
			acc(1'b0, hf_clock_pkg::OFF_LOCK_LO, 8'h00, q);
			acc(1'b0, hf_clock_pkg::OFF_CTRL, 8'h00, c);
			if (c[4] === 1'b1) break;
		end
		chk({15'h0000, c[4]}, 16'h0001);
		chk({8'h00, q}, {8'h00, lo});
		rd(hf_clock_pkg::OFF_LOCK_HI, 8'h3f, hi);
	endtask : read_lock

	// ========================================
	// main sequence
	initial begin
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd(hf_clock_pkg::OFF_CTRL, 8'h0f, 8'h0c);
		rd(hf_clock_pkg::OFF_MUL_LO, 8'hff, 8'hc5);
		rd(hf_clock_pkg::OFF_MUL_HI, 8'hff, 8'h04);
		rd(hf_clock_pkg::OFF_DIV, 8'hff, 8'h0a);
		chk({2'b00, mul_applied_o}, 16'h04c5);
		rd(5'h1c, 8'hff, 8'h00);
		// normal load with a small target so the search ends quickly
		wr(hf_clock_pkg::OFF_DIV, 8'h0a);
		wr(hf_clock_pkg::OFF_MUL_LO, 8'h0e);
		wr(hf_clock_pkg::OFF_MUL_HI, 8'h00);
		rd(hf_clock_pkg::OFF_MUL_LO, 8'hff, 8'hc5);
		wr(hf_clock_pkg::OFF_CTRL, 8'h01);
		@(negedge core_clk_i);
		chk({15'h0000, sys_clk_en_o}, 16'h0000);
		rd(hf_clock_pkg::OFF_CTRL, 8'h0f, 8'h04);
		wait_stable(20000);
		rd(hf_clock_pkg::OFF_CTRL, 8'h0f, 8'h0c);
		rd(hf_clock_pkg::OFF_MUL_LO, 8'hff, 8'h0e);
		chk({2'b00, mul_applied_o}, 16'h000e);
		read_lock(8'h04, 8'h00);
		// fast load with the recorded lock value for 10 MHz
		wr(hf_clock_pkg::OFF_DIV, 8'h0a);
		wr(hf_clock_pkg::OFF_MUL_LO, 8'hec);
		wr(hf_clock_pkg::OFF_MUL_HI, 8'h0b);
		wr(hf_clock_pkg::OFF_LOCK_LO, 8'he6);
		wr(hf_clock_pkg::OFF_LOCK_HI, 8'h0b);
		wr(hf_clock_pkg::OFF_CTRL, 8'h02);
		rd(hf_clock_pkg::OFF_CTRL, 8'h0f, 8'h04);
		wait_stable(1500);
		chk({2'b00, mul_applied_o}, 16'h0bec);
		chk({11'h000, div_applied_o}, 16'h000a);
		read_lock(8'he6, 8'h0b);
		// reference tick spacing
		n = 0;
		do begin
			@(negedge core_clk_i);
			n++;
		end while (ref_tick_o !== 1'b1 && n < 700);
		if (n >= 700) give_up();
		n = 0;
		do begin
			@(negedge core_clk_i);
			n++;
		end while (ref_tick_o !== 1'b1 && n < 700);
		chk(n[15:0], hf_clock_pkg::REF_DIV[15:0]);
		// wait with idle bits clear only halts the core
		strobe(1'b1);
		chk({14'h0000, core_halt_o, idle_o}, 16'h0002);
		strobe(1'b0);
		chk({15'h0000, core_halt_o}, 16'h0000);
		wr(hf_clock_pkg::OFF_PMODE, 8'h24);
		strobe(1'b1);
		chk({14'h0000, idle_o, sys_clk_en_o}, 16'h0002);
		rd(hf_clock_pkg::OFF_CTRL, 8'h04, 8'h04);
		strobe(1'b0);
		rd(hf_clock_pkg::OFF_PMODE, 8'hff, 8'h20);
		wait_stable(3000);
		// idle with the multiplier switched off, then wake
		wr(hf_clock_pkg::OFF_PMODE, 8'h26);
		rd(hf_clock_pkg::OFF_CTRL, 8'h04, 8'h04);
		strobe(1'b1);
		rd(hf_clock_pkg::OFF_CTRL, 8'h04, 8'h00);
		strobe(1'b0);
		chk({15'h0000, idle_o}, 16'h0000);
		rd(hf_clock_pkg::OFF_PMODE, 8'hff, 8'h20);
		wait_stable(3000);
		// a write without byte lane 0 must leave the power mode bits alone
		@(posedge core_clk_i);
		avs_byteenable_i <= 4'h0;
		wr(hf_clock_pkg::OFF_PMODE, 8'h24);
		avs_byteenable_i <= 4'h1;
		rd(hf_clock_pkg::OFF_PMODE, 8'hff, 8'h20);
		// reset in mid-run restores defaults and active mode
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd(hf_clock_pkg::OFF_CTRL, 8'h0f, 8'h0c);
		rd(hf_clock_pkg::OFF_MUL_HI, 8'hff, 8'h04);
		chk({14'h0000, idle_o, core_halt_o}, 16'h0000);
		print_verdict();
	end
endmodule : test_hf_clock_multiplier_power_modes
